// [design/cide_core.sv]
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Word splits into opcode, effect, condition, destination and source fields.
// - Effect bits enable zero write, carry write, result write, immediate source.
// - Flags take per-opcode meanings; undefined ones are don't-care.
// - Result-enable bit decides whether the destination register is written.
// - Memory opcodes with result set load zero-extended byte, word, long.
// - Memory opcodes with result clear store low byte, word or long.
// - Service opcode selects one of eight hub operations by source bits 2..0.
// - Clock set loads clock configuration from destination bits 7..0, no writeback.
// - Core launch returns started index, zero for index zero, no free core in carry.
// - Core halt stops core destination 2..0, zero flag for index zero.
// - Lock allocate returns a free lock number, carry when none free.
// - Lock release returns lock destination 2..0; zero for zero, carry none free.
// - Lock take and drop return prior lock state in carry.
// - Multiply, encode and count opcodes are reserved and do nothing.
// - Rotates use source bits 4..0, take four clocks, carry from end bit.
// - Logical shifts fill zeros, carry from bit 0 or bit 31.
// - Carry-fill shifts fill vacated bits with the carry flag.
// - Arithmetic right shift replicates the sign, carry from bit 0.
// - Bit reverse reverses low 32 minus count bits, zero-extended.
// - Limit opcodes pick source by compare; zero means source zero, carry means below.
// - Field inserts put source 8..0 into destination 8..0, 17..9 or 31..23.
// - Jump loads PC from source 8..0; linked form stores PC plus one.
module cide_core (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] core_index,
   output cide_pkg::cide_hub_req_t hub_req,
   input wire cide_pkg::cide_hub_rsp_t hub_rsp,
   output logic [7:0] clk_cfg
);

   cide_pkg::cide_regs_t s_reg;
   cide_pkg::cide_regs_t s_next;
   cide_pkg::cide_instr_t win;
   cide_pkg::cide_instr_t ins;
   logic [31:0] rf [0:511];
   logic acc;
   logic start;
   logic wok;
   logic commit;
   logic ok;
   logic wen;
   logic rf_we;
   logic zf;
   logic cf;
   logic [2:0] sub;
   logic [2:0] id;
   logic [31:0] dstv;
   logic [31:0] srcv;
   logic [31:0] d_op;
   logic [31:0] s_op;
   logic [31:0] res;
   logic [31:0] rd_ext;
   logic [33:0] alu_out;

   // Condition codes index by {carry, zero}; all ones runs always.
   function automatic logic cide_cond(input logic [3:0] cc, input logic z, input logic c);
      return cc[{c, z}];
   endfunction

   function automatic logic [31:0] cide_size_mask(input logic [1:0] sz);
      case (sz)
         2'h0: return 32'h0000_00FF;
         2'h1: return 32'h0000_FFFF;
         default: return 32'hFFFF_FFFF;
      endcase
   endfunction

   function automatic logic cide_via_hub(input logic [5:0] op, input logic [2:0] sv);
      return (op <= cide_pkg::OP_LONG) || (op == cide_pkg::OP_HUB && sv >= cide_pkg::SVC_CORE_LAUNCH);
   endfunction

   // Returns {result, zero, carry} for every locally executed opcode.
   function automatic logic [33:0] cide_alu(input logic [5:0] op, input logic [31:0] d,
                                            input logic [31:0] s, input logic ci, input logic [8:0] pc);
      logic [4:0] n;
      logic [31:0] r;
      logic [31:0] rv;
      logic [63:0] w;
      logic c;
      logic z;
      n = s[4:0];
      r = d;
      c = 1'b0;
      w = 64'h0;
      rv = {<<{d}};
      case (op)
         cide_pkg::OP_ROR: begin
            w = {d, d} >> n;
            r = w[31:0];
            c = d[0];
         end
         cide_pkg::OP_ROL: begin
            w = {d, d} << n;
            r = w[63:32];
            c = d[31];
         end
         cide_pkg::OP_SHR: begin
            r = d >> n;
            c = d[0];
         end
         cide_pkg::OP_SHL: begin
            r = d << n;
            c = d[31];
         end
         cide_pkg::OP_RCR: begin
            w = {{32{ci}}, d} >> n;
            r = w[31:0];
            c = d[0];
         end
         cide_pkg::OP_RCL: begin
            w = {d, {32{ci}}} << n;
            r = w[63:32];
            c = d[31];
         end
         cide_pkg::OP_SAR: begin
            r = $signed(d) >>> n;
            c = d[0];
         end
         cide_pkg::OP_REV: begin
            r = rv >> n;
            c = d[0];
         end
         cide_pkg::OP_SIGNED_LOWER_LIMIT: begin
            c = $signed(d) < $signed(s);
            r = c ? s : d;
         end
         cide_pkg::OP_SIGNED_UPPER_LIMIT: begin
            c = $signed(d) < $signed(s);
            r = c ? d : s;
         end
         cide_pkg::OP_MIN: begin
            c = d < s;
            r = c ? s : d;
         end
         cide_pkg::OP_MAX: begin
            c = d < s;
            r = c ? d : s;
         end
         cide_pkg::OP_INS_LO: r = {d[31:9], s[8:0]};
         cide_pkg::OP_INS_MID: r = {d[31:18], s[8:0], d[8:0]};
         cide_pkg::OP_INS_TOP: r = {s[8:0], d[22:0]};
         cide_pkg::OP_JMP: r = {d[31:9], 9'(pc + 9'h001)};
         default: r = d;
      endcase
      z = (op >= cide_pkg::OP_SIGNED_LOWER_LIMIT && op <= cide_pkg::OP_MAX) ? (s == 32'h0) : (r == 32'h0);
      return {r, z, c};
   endfunction

   always_comb begin
      s_next = s_reg;
      win = cide_pkg::cide_instr_t'(pwdata);
      ins = s_reg.ins;
      dstv = rf[win.dst];
      srcv = win.imm ? {23'h0, win.src} : rf[win.src];
      d_op = s_reg.dval;
      s_op = s_reg.sval;
      sub = s_op[2:0];
      acc = psel && penable;
      pready = !(pwrite && s_reg.st != cide_pkg::CIDE_IDLE);
      start = acc && pwrite && paddr == cide_pkg::OFF_INSTR && s_reg.st == cide_pkg::CIDE_IDLE;
      wok = cide_cond(win.cond, s_reg.z, s_reg.c);
      ok = cide_cond(ins.cond, s_reg.z, s_reg.c);
      alu_out = cide_alu(ins.op, d_op, s_op, s_reg.c, s_reg.pc);
      rd_ext = hub_rsp.rdata & cide_size_mask(ins.op[1:0]);
      commit = 1'b0;
      rf_we = 1'b0;
      wen = 1'b0;
      id = 3'h0;
      res = alu_out[33:2];
      zf = alu_out[1];
      cf = alu_out[0];
      case (s_reg.st)
         cide_pkg::CIDE_IDLE: begin
            if (start) begin
               s_next.ins = win;
               s_next.dval = dstv;
               s_next.sval = srcv;
               s_next.cnt = 2'h0;
               s_next.st = cide_pkg::CIDE_EXEC;
               // A false condition still spends its four-clock slot but touches no hub.
               if (wok && win.op >= cide_pkg::OP_MUL && win.op <= cide_pkg::OP_ONES) begin
                  s_next.st = cide_pkg::CIDE_IDLE;
               end else if (wok && cide_via_hub(win.op, srcv[2:0])) begin
                  s_next.st = cide_pkg::CIDE_HUB;
                  s_next.hub.valid = 1'b1;
                  s_next.hub.addr = srcv[15:0];
                  if (win.op == cide_pkg::OP_HUB) begin
                     s_next.hub.cmd = {1'b1, srcv[2:0]};
                     s_next.hub.wdata = dstv;
                  end else begin
                     s_next.hub.cmd = {1'b0, win.ren, win.op[1:0]};
                     s_next.hub.wdata = dstv & cide_size_mask(win.op[1:0]);
                  end
               end
            end
         end
         cide_pkg::CIDE_EXEC: begin
            s_next.cnt = 2'(s_reg.cnt + 2'h1);
            if (s_reg.cnt == cide_pkg::EXEC_LAST) begin
               commit = 1'b1;
               s_next.st = cide_pkg::CIDE_IDLE;
            end
         end
         cide_pkg::CIDE_HUB: begin
            if (hub_rsp.ack) begin
               commit = 1'b1;
               s_next.hub.valid = 1'b0;
               s_next.st = cide_pkg::CIDE_IDLE;
            end
         end
         default: s_next.st = cide_pkg::CIDE_IDLE;
      endcase
      if (commit) begin
         wen = ins.ren;
         s_next.pc = 9'(s_reg.pc + 9'h001);
         if (ins.op <= cide_pkg::OP_LONG) begin
            res = rd_ext;
            zf = (rd_ext == 32'h0);
            cf = 1'b0;
         end
         if (ins.op == cide_pkg::OP_HUB) begin
            // Launch and allocate report the hub's index; the others echo the operand.
            id = (sub == cide_pkg::SVC_CORE_LAUNCH || sub == cide_pkg::SVC_LOCK_ALLOC) ?
                 hub_rsp.rdata[2:0] : d_op[2:0];
            res = {29'h0, id};
            zf = (id == 3'h0);
            cf = hub_rsp.carry;
            if (sub == cide_pkg::SVC_CORE_INDEX) begin
               res = {29'h0, core_index};
               zf = (core_index == 3'h0);
               cf = 1'b0;
            end
            if (sub == cide_pkg::SVC_CLOCK_SET) begin
               wen = 1'b0;
               if (ok) begin
                  s_next.clk_cfg = d_op[7:0];
               end
            end
         end
         if (ok && ins.op == cide_pkg::OP_JMP) begin
            s_next.pc = s_op[8:0];
         end
         if (ok) begin
            if (ins.zen) begin
               s_next.z = zf;
            end
            if (ins.cen) begin
               s_next.c = cf;
            end
            rf_we = wen;
         end
      end
      // Writes stall while busy, so software never races a commit.
      if (acc && pwrite && pready) begin
         if (paddr == cide_pkg::OFF_STATUS) begin
            s_next.z = pwdata[cide_pkg::ST_Z];
            s_next.c = pwdata[cide_pkg::ST_C];
         end
         if (paddr == cide_pkg::OFF_RIDX) begin
            s_next.ridx = pwdata[8:0];
         end
      end
      pslverr = acc && !(paddr == cide_pkg::OFF_INSTR || paddr == cide_pkg::OFF_STATUS ||
                paddr == cide_pkg::OFF_RIDX || paddr == cide_pkg::OFF_RDATA || paddr == cide_pkg::OFF_CLKCFG);
      case (paddr)
         cide_pkg::OFF_INSTR: prdata = s_reg.ins;
         cide_pkg::OFF_STATUS: prdata = {19'h0, s_reg.pc, 1'b0, s_reg.c, s_reg.z,
                                         s_reg.st != cide_pkg::CIDE_IDLE};
         cide_pkg::OFF_RIDX: prdata = {23'h0, s_reg.ridx};
         cide_pkg::OFF_RDATA: prdata = rf[s_reg.ridx];
         cide_pkg::OFF_CLKCFG: prdata = {24'h0, s_reg.clk_cfg};
         default: prdata = 32'h0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_reg <= cide_pkg::REGS_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // The register memory has no reset; software loads it before use.
   always_ff @(posedge clk) begin
      if (rf_we) begin
         rf[ins.dst] <= res;
      end else if (acc && pwrite && pready && paddr == cide_pkg::OFF_RDATA) begin
         rf[s_reg.ridx] <= pwdata;
      end
   end

   assign hub_req = s_reg.hub;
   assign clk_cfg = s_reg.clk_cfg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   chk_alu_four_clk: assert property (
      start && win.op[5:3] == 3'h1 |=> (s_reg.st == cide_pkg::CIDE_EXEC) [*4] ##1 (s_reg.st == cide_pkg::CIDE_IDLE))
      else $error("Shift group did not take four clocks.");
   chk_shr_value: assert property (
      commit && ins.op == cide_pkg::OP_SHR |-> res == (d_op >> s_op[4:0]) && cf == d_op[0])
      else $error("Logical right shift result wrong.");
   chk_hub_req_hold: assert property (
      hub_req.valid && !(hub_rsp.ack && s_reg.st == cide_pkg::CIDE_HUB)
      |=> hub_req.valid && $stable(hub_req.addr) && $stable(hub_req.cmd))
      else $error("Hub request changed before acknowledge.");
   chk_store_no_wb: assert property (
      commit && ins.op <= cide_pkg::OP_LONG && !ins.ren |-> !rf_we)
      else $error("Store wrote the destination.");
   chk_false_cond: assert property (
      commit && !ok |-> !rf_we ##1 ($stable(s_reg.z) && $stable(s_reg.c)))
      else $error("False condition changed state.");
   chk_core_index: assert property (
      commit && ok && ins.op == cide_pkg::OP_HUB && sub == cide_pkg::SVC_CORE_INDEX
      |-> res == {29'h0, core_index} && !cf)
      else $error("Core index query returned wrong value.");
   chk_clock_set: assert property (
      commit && ok && ins.op == cide_pkg::OP_HUB && sub == cide_pkg::SVC_CLOCK_SET
      |-> !rf_we ##1 clk_cfg == $past(d_op[7:0]))
      else $error("Clock configuration not loaded.");
   chk_reserved_nop: assert property (
      start && wok && win.op >= cide_pkg::OP_MUL && win.op <= cide_pkg::OP_ONES
      |=> s_reg.st == cide_pkg::CIDE_IDLE && !hub_req.valid)
      else $error("Reserved opcode did something.");
   chk_jump_pc: assert property (
      commit && ok && ins.op == cide_pkg::OP_JMP |=> s_reg.pc == $past(s_op[8:0]))
      else $error("Jump did not load the program counter.");
   chk_store_mask: assert property (
      hub_req.valid && hub_req.cmd[3:2] == 2'h0 |-> (hub_req.wdata & ~cide_size_mask(hub_req.cmd[1:0])) == 32'h0)
      else $error("Store data not masked to size.");
   chk_load_extend: assert property (
      commit && ins.op <= cide_pkg::OP_LONG && ins.ren
      |-> (res & ~cide_size_mask(ins.op[1:0])) == 32'h0 && zf == (res == 32'h0))
      else $error("Load result not zero-extended.");
   chk_hub_release: assert property (
      hub_rsp.ack && s_reg.st == cide_pkg::CIDE_HUB |=> !hub_req.valid && s_reg.st == cide_pkg::CIDE_IDLE)
      else $error("Hub request not released after acknowledge.");
   chk_skip_no_hub: assert property (
      start && !wok |=> !hub_req.valid && s_reg.st == cide_pkg::CIDE_EXEC)
      else $error("False condition reached the hub.");
   chk_pc_step: assert property (
      commit && !(ok && ins.op == cide_pkg::OP_JMP) |=> s_reg.pc == 9'($past(s_reg.pc) + 9'h001))
      else $error("Program counter did not step by one.");
   chk_lock_carry: assert property (
      commit && ok && ins.op == cide_pkg::OP_HUB && ins.cen && sub >= cide_pkg::SVC_CORE_LAUNCH
      |=> s_reg.c == $past(hub_rsp.carry))
      else $error("Hub carry not returned in the carry flag.");

   cov_hub_op: cover property (commit && ok && ins.op == cide_pkg::OP_HUB);
   cov_mem_read: cover property (commit && ok && ins.op == cide_pkg::OP_LONG && ins.ren);
   cov_cond_skip: cover property (commit && !ok);
   cov_rotate: cover property (commit && ok && ins.op == cide_pkg::OP_ROR);
   cov_lock_none: cover property (commit && ok && ins.op == cide_pkg::OP_HUB &&
      sub == cide_pkg::SVC_LOCK_ALLOC && hub_rsp.carry);

endmodule

// [design/cide_pkg.sv]
package cide_pkg;
   // APB register offsets (byte addresses) and status bit positions.
   localparam logic [7:0] OFF_INSTR = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_RIDX = 8'h08;
   localparam logic [7:0] OFF_RDATA = 8'h0C;
   localparam logic [7:0] OFF_CLKCFG = 8'h10;
   localparam int ST_BUSY = 0;
   localparam int ST_Z = 1;
   localparam int ST_C = 2;
   localparam int ST_PC = 4;
   localparam logic [7:0] CLKCFG_RESET = 8'h00;
   localparam logic [8:0] PC_RESET = 9'h000;
   localparam int EXEC_CLOCKS = 4;
   localparam logic [1:0] EXEC_LAST = 2'(EXEC_CLOCKS - 1);
   localparam logic [3:0] COND_ALWAYS = 4'hF;
   localparam logic [5:0] OP_BYTE = 6'h00;
   localparam logic [5:0] OP_WORD = 6'h01;
   localparam logic [5:0] OP_LONG = 6'h02;
   localparam logic [5:0] OP_HUB = 6'h03;
   localparam logic [5:0] OP_MUL = 6'h04;
   localparam logic [5:0] OP_ONES = 6'h07;
   localparam logic [5:0] OP_ROR = 6'h08;
   localparam logic [5:0] OP_ROL = 6'h09;
   localparam logic [5:0] OP_SHR = 6'h0A;
   localparam logic [5:0] OP_SHL = 6'h0B;
   localparam logic [5:0] OP_RCR = 6'h0C;
   localparam logic [5:0] OP_RCL = 6'h0D;
   localparam logic [5:0] OP_SAR = 6'h0E;
   localparam logic [5:0] OP_REV = 6'h0F;
   localparam logic [5:0] OP_SIGNED_LOWER_LIMIT = 6'h10;
   localparam logic [5:0] OP_SIGNED_UPPER_LIMIT = 6'h11;
   localparam logic [5:0] OP_MIN = 6'h12;
   localparam logic [5:0] OP_MAX = 6'h13;
   localparam logic [5:0] OP_INS_LO = 6'h14;
   localparam logic [5:0] OP_INS_MID = 6'h15;
   localparam logic [5:0] OP_INS_TOP = 6'h16;
   localparam logic [5:0] OP_JMP = 6'h17;
   localparam logic [2:0] SVC_CLOCK_SET = 3'h0;
   localparam logic [2:0] SVC_CORE_INDEX = 3'h1;
   localparam logic [2:0] SVC_CORE_LAUNCH = 3'h2;
   localparam logic [2:0] SVC_LOCK_ALLOC = 3'h4;
   typedef enum logic [2:0] {
      CIDE_IDLE = 3'h1,
      CIDE_EXEC = 3'h2,
      CIDE_HUB = 3'h4
   } cide_state_t;
   typedef struct packed {
      logic [5:0] op;
      logic zen;
      logic cen;
      logic ren;
      logic imm;
      logic [3:0] cond;
      logic [8:0] dst;
      logic [8:0] src;
   } cide_instr_t;
   // Hub command: bit 3 set is a service op with code in [2:0]; clear is memory {ren, size}.
   typedef struct packed {
      logic valid;
      logic [3:0] cmd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } cide_hub_req_t;
   typedef struct packed {
      logic ack;
      logic carry;
      logic [31:0] rdata;
   } cide_hub_rsp_t;
   typedef struct packed {
      cide_state_t st;
      logic [1:0] cnt;
      cide_instr_t ins;
      logic [31:0] dval;
      logic [31:0] sval;
      logic [8:0] pc;
      logic [8:0] ridx;
      logic z;
      logic c;
      logic [7:0] clk_cfg;
      cide_hub_req_t hub;
   } cide_regs_t;
   localparam cide_regs_t REGS_RESET = '{st: CIDE_IDLE, pc: PC_RESET, clk_cfg: CLKCFG_RESET, default: '0};
endpackage

// [testbench/cide_core_test.sv]
`timescale 1ns/1ps
module cide_core_test;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, slow, serr;
   logic [7:0] paddr, clk_cfg;
   logic [31:0] pwdata, prdata, q, g, st, dv, sv;
   logic [2:0] core_index;
   logic [32:0] e;
   logic [8:0] p;
   logic [5:0] op;
   cide_pkg::cide_hub_req_t hub_req;
   cide_pkg::cide_hub_rsp_t hub_rsp;
   int err_count, samples_checked;

   cide_core u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_index(core_index), .hub_req(hub_req), .hub_rsp(hub_rsp), .clk_cfg(clk_cfg));
   cide_hub_model u_hub (.clk(clk), .sys_rst(sys_rst), .slow(slow), .hub_req(hub_req), .hub_rsp(hub_rsp));

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
      samples_checked++;
      if (y !== x) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, x, y);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic setr(input logic [8:0] i, input logic [31:0] v);
      apb(1'b1, cide_pkg::OFF_RIDX, 32'(i), q);
      apb(1'b1, cide_pkg::OFF_RDATA, v, q);
   endtask

   task automatic getr(input logic [8:0] i);
      apb(1'b1, cide_pkg::OFF_RIDX, 32'(i), q);
      apb(1'b0, cide_pkg::OFF_RDATA, 32'h0, g);
   endtask

   task automatic run(input logic [5:0] o, input logic [3:0] f, input logic [3:0] cc, input logic [8:0] d,
      input logic [8:0] s);
      apb(1'b1, cide_pkg::OFF_INSTR, {o, f, cc, d, s}, q);
      do begin
         apb(1'b0, cide_pkg::OFF_STATUS, 32'h0, st);
      end while (st[0] !== 1'b0);
   endtask

   function automatic logic [32:0] alu(input logic [5:0] o, input logic [31:0] d, input logic [31:0] s,
      input logic ci);
      logic [4:0] n;
      logic [31:0] r;
      logic c;
      n = s[4:0];
      c = o[0] ? d[31] : d[0];
      r = d;
      case (o)
         cide_pkg::OP_ROR: r = 32'({d, d} >> n);
         cide_pkg::OP_ROL: r = 32'(({d, d} << n) >> 32);
         cide_pkg::OP_SHR: r = d >> n;
         cide_pkg::OP_SHL: r = d << n;
         cide_pkg::OP_RCR: r = (d >> n) | ({32{ci}} & ~(32'hFFFFFFFF >> n));
         cide_pkg::OP_RCL: r = (d << n) | ({32{ci}} & ~(32'hFFFFFFFF << n));
         cide_pkg::OP_SAR: r = $signed(d) >>> n;
         cide_pkg::OP_REV: begin
            r = {<<{d}};
            r = r >> n;
            c = d[0];
         end
         cide_pkg::OP_INS_LO: r = {d[31:9], s[8:0]};
         cide_pkg::OP_INS_MID: r = {d[31:18], s[8:0], d[8:0]};
         cide_pkg::OP_INS_TOP: r = {s[8:0], d[22:0]};
         default: begin
            c = o[1] ? d < s : $signed(d) < $signed(s);
            r = (c ^ o[0]) ? s : d;
         end
      endcase
      return {c, r};
   endfunction

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_sim;
   end

   initial begin
      err_count = 0;
      samples_checked = 0;
      {sys_rst, psel, penable, pwrite, paddr, pwdata, slow, serr} = {1'b1, 45'h0};
      core_index = 3'h5;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk("clk_cfg", 32'(cide_pkg::CLKCFG_RESET), clk_cfg);
      chk("hub valid", 32'h0, hub_req.valid);
      apb(1'b0, 8'h14, 32'h0, g);
      chk("slverr", 32'h1, serr);
      chk("unmapped data", 32'h0, g);
      for (int k = 0; k < 4; k++) begin
         for (int o = 8; o <= 22; o++) begin
            op = 6'(o);
            dv = k[0] ? 32'h8000_0013 : 32'h0000_0005;
            sv = k[1] ? 32'h0 : 32'h0000_0127;
            setr(9'h1, dv);
            setr(9'h2, sv);
            apb(1'b1, cide_pkg::OFF_STATUS, {29'h0, k[0], 2'h0}, q);
            e = alu(op, dv, sv, k[0]);
            run(op, 4'hE, 4'hF, 9'h1, 9'h2);
            getr(9'h1);
            chk("result", e[31:0], g);
            chk("z", (op inside {[cide_pkg::OP_SIGNED_LOWER_LIMIT:cide_pkg::OP_MAX]}) ? sv == 0 : e[31:0] == 0, st[1]);
            if (op < cide_pkg::OP_INS_LO) chk("c", e[32], st[2]);
         end
      end
      setr(9'h3, 32'h1234_565A);
      run(cide_pkg::OP_HUB, 4'h1, 4'hF, 9'h3, 9'h000);
      apb(1'b0, cide_pkg::OFF_CLKCFG, 32'h0, g);
      chk("clk_cfg", 32'h5A, g);
      apb(1'b1, cide_pkg::OFF_CLKCFG, 32'hFF, q);
      chk("clk_cfg", 32'h5A, clk_cfg);
      getr(9'h3);
      chk("dest", 32'h1234_565A, g);
      for (int i = 0; i < 2; i++) begin
         core_index <= i[0] ? 3'h0 : 3'h5;
         run(cide_pkg::OP_HUB, 4'hF, 4'hF, 9'h4, 9'h001);
         getr(9'h4);
         chk("core idx", i[0] ? 32'h0 : 32'h5, g);
         chk("flags", {30'h0, i[0]}, st[2:1]);
      end
      for (int i = 0; i < 9; i++) begin
         run(cide_pkg::OP_HUB, 4'hF, 4'hF, 9'h5, 9'h004);
         getr(9'h5);
         if (i < 8) chk("lock id", i, g);
         chk("flags", {i == 8, i == 0 || i == 8}, st[2:1]);
      end
      setr(9'h6, 32'h3);
      for (int i = 0; i < 4; i++) begin
         run(cide_pkg::OP_HUB, 4'h5, 4'hF, 9'h6, 9'h006 + 9'(i[1]));
         chk("prior lock", i == 1 || i == 2, st[2]);
      end
      run(cide_pkg::OP_HUB, 4'hD, 4'hF, 9'h6, 9'h005);
      chk("none free", 32'h2, st[2:1]);
      run(cide_pkg::OP_HUB, 4'hF, 4'hF, 9'h5, 9'h004);
      getr(9'h5);
      chk("lock id", 32'h3, g);
      slow <= 1'b1;
      setr(9'h7, 32'h0);
      for (int i = 0; i < 8; i++) begin
         run(cide_pkg::OP_HUB, 4'hD, 4'hF, 9'h7, 9'h002);
         chk("launch", {i == 7, i == 7}, st[2:1]);
      end
      run(cide_pkg::OP_HUB, 4'h9, 4'hF, 9'h7, 9'h003);
      chk("halt z", 32'h1, st[1]);
      run(cide_pkg::OP_HUB, 4'hD, 4'hF, 9'h7, 9'h002);
      chk("launch", 32'h1, st[2:1]);
      getr(9'h7);
      chk("dest", 32'h0, g);
      setr(9'h8, 32'hCAFE_F00D);
      setr(9'h9, 32'hFFFF_5577);
      apb(1'b1, cide_pkg::OFF_INSTR, {cide_pkg::OP_LONG, 8'h1F, 9'h8, 9'h040}, q);
      repeat (2) @(posedge clk);
      chk("hub req", 32'h0012_0040, {hub_req.valid, hub_req.cmd, hub_req.addr});
      chk("hub data", 32'hCAFE_F00D, hub_req.wdata);
      run(cide_pkg::OP_BYTE, 4'h1, 4'hF, 9'h9, 9'h041);
      run(cide_pkg::OP_LONG, 4'hB, 4'hF, 9'hA, 9'h040);
      getr(9'hA);
      chk("load long", 32'hCAFE_770D, g);
      run(cide_pkg::OP_WORD, 4'hB, 4'hF, 9'hA, 9'h042);
      getr(9'hA);
      chk("load word", 32'h0000_CAFE, g);
      run(cide_pkg::OP_WORD, 4'h1, 4'hF, 9'h9, 9'h042);
      run(cide_pkg::OP_BYTE, 4'hB, 4'hF, 9'hA, 9'h043);
      getr(9'hA);
      chk("load byte", 32'h0000_0055, g);
      run(cide_pkg::OP_WORD, 4'hB, 4'hF, 9'hA, 9'h040);
      chk("load z", 32'h0, st[1]);
      getr(9'h9);
      chk("store dest", 32'hFFFF_5577, g);
      slow <= 1'b0;
      setr(9'hB, 32'h0000_00F0);
      apb(1'b1, cide_pkg::OFF_STATUS, 32'h2, q);
      run(cide_pkg::OP_SHL, 4'hF, 4'h2, 9'hB, 9'h004);
      apb(1'b1, cide_pkg::OFF_STATUS, 32'h6, q);
      p = st[12:4];
      run(cide_pkg::OP_SHL, 4'hF, 4'h7, 9'hB, 9'h004);
      getr(9'hB);
      chk("cond", 32'h0000_0F00, g);
      chk("cond flags", 32'h3, st[2:1]);
      chk("cond pc", 32'(p + 9'h1), st[12:4]);
      setr(9'hC, 32'hFFFF_FFFF);
      p = st[12:4];
      run(cide_pkg::OP_JMP, 4'h3, 4'hF, 9'hC, 9'h1A5);
      chk("jump pc", 32'h1A5, st[12:4]);
      run(cide_pkg::OP_JMP, 4'h1, 4'hF, 9'hC, 9'h033);
      chk("jump pc", 32'h033, st[12:4]);
      getr(9'hC);
      chk("link", {23'h7FFFFF, p + 9'h1}, g);
      setr(9'hD, 32'h1234_5678);
      for (int o = 4; o < 8; o++) begin
         run(6'(o), 4'hF, 4'hF, 9'hD, 9'h003);
         chk("reserved pc", 32'h033, st[12:4]);
      end
      getr(9'hD);
      chk("reserved", 32'h1234_5678, g);
      end_sim;
   end
endmodule

// [testbench/cide_hub_model.sv]
`timescale 1ns/1ps
module cide_hub_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic slow,
   input wire cide_pkg::cide_hub_req_t hub_req,
   output cide_pkg::cide_hub_rsp_t hub_rsp
);
   logic [7:0] mem [logic [15:0]];
   logic [7:0] locks_out, locks_set, cores_on;
   logic [31:0] r;
   logic [15:0] a;
   logic [2:0] w;
   logic c, pend;
   logic [3:0] cnt;

   function automatic logic [2:0] first_free(input logic [7:0] m);
      logic [2:0] f;
      f = 3'h0;
      for (int j = 7; j >= 0; j--) if (!m[j]) f = 3'(j);
      return f;
   endfunction

   always @(posedge clk) begin
      hub_rsp.ack <= 1'b0;
      // Between answers the data wanders, so a stale word is never taken for a fresh one.
      hub_rsp.rdata <= ~hub_rsp.rdata;
      if (sys_rst) begin
         pend <= 1'b0;
         hub_rsp <= '0;
         locks_out = 8'h00;
         locks_set = 8'h00;
         // One core is already running when the chip comes out of reset.
         cores_on = 8'h01;
      end else if (pend && cnt == 4'h0) begin
         w = hub_req.wdata[2:0];
         a = hub_req.addr & ~16'((1 << hub_req.cmd[1:0]) - 1);
         r = 32'h0;
         c = 1'b0;
         if (!hub_req.cmd[3]) begin
            for (int i = 0; i < 4; i++) begin
               if (hub_req.cmd[2]) r[8*i+:8] = mem.exists(a + 16'(i)) ? mem[a + 16'(i)] : 8'hA5 ^ 8'(i);
               else if (i < (1 << hub_req.cmd[1:0])) mem[a + 16'(i)] = hub_req.wdata[8*i+:8];
            end
         end else begin
            case (hub_req.cmd[2:0])
               3'h2: begin
                  c = &cores_on;
                  r = 32'(first_free(cores_on));
                  if (!c) cores_on[r[2:0]] = 1'b1;
               end
               3'h3: cores_on[w] = 1'b0;
               3'h4: begin
                  c = &locks_out;
                  r = 32'(first_free(locks_out));
                  if (!c) locks_out[r[2:0]] = 1'b1;
               end
               3'h5: begin
                  c = &locks_out;
                  locks_out[w] = 1'b0;
               end
               3'h6: begin
                  c = locks_set[w];
                  locks_set[w] = 1'b1;
               end
               3'h7: begin
                  c = locks_set[w];
                  locks_set[w] = 1'b0;
               end
               default: c = 1'b0;
            endcase
         end
         pend <= 1'b0;
         hub_rsp.ack <= 1'b1;
         hub_rsp.carry <= c;
         hub_rsp.rdata <= r;
      end else if (pend) begin
         cnt <= cnt - 4'h1;
      end else if (hub_req.valid && !hub_rsp.ack) begin
         pend <= 1'b1;
         cnt <= slow ? 4'h6 : 4'h0;
      end
   end
endmodule
